//--- hdl/rtca_pkg.sv
// shared constants and types of the alarm, protect and trim control block
package rtca_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_PROT  = 6'h10;
  localparam logic [5:0] IDX_IRQ   = 6'h11;
  localparam logic [5:0] IDX_ATRIM = 6'h12;
  localparam logic [5:0] IDX_DTRIM = 6'h13;
  localparam logic [5:0] IDX_PSW   = 6'h14;
  localparam logic [5:0] IDX_STAT  = 6'h3F;
  localparam logic [2:0] FLD_YR   = 3'h5;
  localparam logic [2:0] FLD_Y2K  = 3'h7;
  localparam int         ALM_SEL  = 3;
  // field positions
  localparam int ST_BAT       = 7;
  localparam int ST_FLAG1     = 6;
  localparam int ST_FLAG0     = 5;
  localparam int ST_UNUSED    = 3;
  localparam int PROT_SEL_LSB = 5;
  localparam int IRQ_PULSED   = 7;
  localparam int IRQ_EN1      = 6;
  localparam int IRQ_EN0      = 5;
  localparam int IRQ_FREQ_LSB = 3;
  localparam int PSW_BUS_OFF  = 7;
  localparam int PSW_POLICY   = 6;
  localparam int ALM_EN       = 7;
  localparam int DT_SIGN      = 2;
  localparam int DT_10PPM     = 1;
  localparam int DT_20PPM     = 0;
  localparam int AT_MSB       = 5;
  // reset values
  localparam logic [2:0] BP_RST  = 3'h0;
  localparam logic [7:0] IRQ_RST = 8'h00;
  localparam logic [5:0] AT_RST  = 6'h00;
  localparam logic [2:0] DT_RST  = 3'h0;
  // block protect codes and bounds
  localparam logic [2:0] BP_NONE = 3'h0;
  localparam logic [2:0] BP_UPQ  = 3'h1;
  localparam logic [2:0] BP_UPH  = 3'h2;
  localparam logic [2:0] BP_ALL  = 3'h3;
  localparam logic [2:0] BP_P4   = 3'h4;
  localparam logic [2:0] BP_P8   = 3'h5;
  localparam logic [2:0] BP_P16  = 3'h6;
  localparam logic [2:0] BP_ALL2 = 3'h7;
  localparam logic [8:0] PA_UPQ  = 9'h180;
  localparam logic [8:0] PA_UPH  = 9'h100;
  localparam logic [8:0] PA_P4   = 9'h03F;
  localparam logic [8:0] PA_P8   = 9'h07F;
  localparam logic [8:0] PA_P16  = 9'h0FF;
  // shared pin sources
  localparam logic [1:0] FO_ALARM = 2'h0;
  localparam logic [1:0] FO_32K   = 2'h1;
  localparam logic [1:0] FO_4K    = 2'h2;
  localparam logic [1:0] FO_1HZ   = 2'h3;
  localparam int         FDIV_W   = 3;
  // trim figures
  localparam logic [5:0] PPM_STEP_LO = 6'h0A;
  localparam logic [5:0] PPM_STEP_HI = 6'h14;
  localparam logic [31:0] PPM_SCALE  = 32'h000F4240;
  localparam logic [6:0] CAP_BASE_HALFPF = 7'h12;
  // supply reset threshold codes
  typedef enum logic [2:0] {
    VT_4V64 = 3'h0, VT_4V38 = 3'h1, VT_3V09 = 3'h2, VT_2V92 = 3'h3, VT_2V63 = 3'h4
  } rtca_vts_t;
  typedef enum logic [1:0] {PS_IDLE = 2'b01, PS_PULSE = 2'b10} rtca_pst_t;
  // time bytes, seconds in the low byte, index equals alarm field index
  typedef struct packed {
    logic [7:0] dw;
    logic [7:0] yr;
    logic [7:0] mo;
    logic [7:0] dt;
    logic [7:0] hr;
    logic [7:0] mn;
    logic [7:0] sc;
  } rtca_time_t;
  typedef struct packed {
    logic       req;
    logic [8:0] addr;
  } rtca_memwr_t;
endpackage

//--- hdl/rtca_ctrl.sv
// alarm compare, array write protect, pin select, trim and supply reset control
//
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps

// What this block does
// - status bit 3 always reads zero; host writes it as zero.
// - alarm bytes mirror time bytes; bit 7 enables comparing that field.
// - year never joins the alarm compare.
// - alarm fires when all enabled fields equal time; any subset may be enabled.
// - writes into the protected range are dropped.
// - code 0 none, 1 180h-1FFh, 2 100h-1FFh, 3 and 7 whole array.
// - code 4 000h-03Fh, 5 000h-07Fh, 6 000h-0FFh.
// - alarm on pin only with an alarm enable set and select code 00.
// - pulsed mode pulses pin on every match, repeatedly.
// - either alarm activates pin; in pulsed mode each gets its own pulse.
// - select 00 alarm, 01 32.768kHz, 10 4096Hz, 11 1Hz.
// - digital trim alters counts per second, averaging the error.
// - trim top bit is sign; 000 and 100 mean no correction.
// - middle trim bit 10ppm, lowest 20ppm, up to 30ppm.
// - capacitor code: inverted msb 16, then 8,4,2,1,0.5 pF plus 9pF.
// - bus-off bit disables serial bus in battery mode; default 0.
// - power-switch bit: 0 standard policy, 1 legacy policy.
// - threshold code selects 4.64, 4.38, 3.09, 2.92 or 2.63 V.
// - threshold field is never write protected.
// - in battery mode reset goes low below threshold, held until mains return.
// - alarm flags set on match always; cleared by a status read.
module rtca_ctrl
  import rtca_pkg::*;
#(
  parameter int         OSC_PER_SEC = 32768,
  parameter int         PULSE_OSC   = 16,
  parameter logic       DEF_BSW     = 1'b1,
  parameter logic [2:0] DEF_VTS     = 3'h0
) (
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire rtca_time_t  time_i,
  input  wire rtca_memwr_t mem_wr_i,
  output logic             mem_wr_en_o,
  input  wire logic        osc_clk_i,
  input  wire logic        battery_mode_i,
  input  wire logic        vdd_low_i,
  output logic             irq_freq_pin_o,
  output logic             sec_tick_o,
  output logic      [6:0]  cap_code_o,
  output logic      [5:0]  trim_ppm_o,
  output logic      [2:0]  thresh_sel_o,
  output logic             supply_switch_policy_o,
  output logic             bus_enable_o,
  output logic             rst_n_o
);
  localparam int CNT_W = $clog2(OSC_PER_SEC) + 1;
  localparam int PW    = $clog2(PULSE_OSC) + 1;

  if (OSC_PER_SEC < 64 || OSC_PER_SEC > 32768) begin : g_chk_osc
    $error("OSC_PER_SEC out of range");
  end
  if (PULSE_OSC < 1 || PULSE_OSC > 255) begin : g_chk_pulse
    $error("PULSE_OSC out of range");
  end

  // synchronisers: stage one feeds stage two only
  logic [2:0] osc_sy;
  logic [1:0] bat_sy;
  logic [1:0] vlow_sy;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      osc_sy  <= 3'h0;
      bat_sy  <= 2'h0;
      vlow_sy <= 2'h0;
    end else if (ce_i) begin
      osc_sy  <= {osc_sy[1:0], osc_clk_i};
      bat_sy  <= {bat_sy[0], battery_mode_i};
      vlow_sy <= {vlow_sy[0], vdd_low_i};
    end
  end
  logic osc_s, osc_rise, bat_s, vlow_s;
  assign osc_s    = osc_sy[1];
  assign osc_rise = osc_sy[1] & ~osc_sy[2];
  assign bat_s    = bat_sy[1];
  assign vlow_s   = vlow_sy[1];

  // register file state
  logic [7:0] alarm [2][8];
  logic [7:0] next_alarm [2][8];
  logic [2:0] bp, next_bp;
  logic [7:0] intc, next_intc;
  logic [5:0] atrim, next_atrim;
  logic [2:0] dtrim, next_dtrim;
  logic       bus_off, next_bus_off, policy, next_policy;
  logic [2:0] vts, next_vts;
  logic [1:0] flag, next_flag;
  logic       ack, next_ack;
  logic [7:0] dat, next_dat, rd_val;

  logic [5:0] idx;
  logic       req_new, fire, wr_fire, sr_rd_fire, alm_addr;
  assign idx        = wb_adr_i[7:2];
  assign req_new    = wb_cyc_i & wb_stb_i & ~ack;
  // request is acked one cycle late; write lands on the edge the master sees ack
  assign fire       = wb_cyc_i & wb_stb_i & ack;
  assign wr_fire    = fire & wb_we_i & wb_sel_i[0];
  assign sr_rd_fire = fire & ~wb_we_i & (idx == IDX_STAT);
  assign alm_addr   = (idx[5:4] == 2'b00) && (idx[2:0] != FLD_YR) && (idx[2:0] != FLD_Y2K);
  assign wb_ack_o   = ack;
  assign wb_dat_o   = {24'h000000, dat};

  logic [1:0] fo_sel;
  logic       pulsed, match_any_en;
  logic [1:0] alen;
  assign fo_sel = intc[IRQ_FREQ_LSB +: 2];
  assign pulsed = intc[IRQ_PULSED];
  assign alen   = {intc[IRQ_EN1], intc[IRQ_EN0]};
  assign match_any_en = |alen;

  // alarm compare per alarm and per field
  logic [1:0][6:0] fld_ok;
  logic [1:0][6:0] fld_en;
  logic [1:0]      match, match_q, match_rise;
  for (genvar a = 0; a < 2; a++) begin : g_alm
    for (genvar f = 0; f < 7; f++) begin : g_fld
      if (f == 5) begin : g_year
        assign fld_ok[a][f] = 1'b1;
        assign fld_en[a][f] = 1'b0;
      end else begin : g_cmp
        assign fld_en[a][f] = alarm[a][f][ALM_EN];
        assign fld_ok[a][f] = ~fld_en[a][f] |
                              (alarm[a][f][6:0] == time_i[8*f +: 7]);
      end
    end
    assign match[a] = (&fld_ok[a]) & (|fld_en[a]);
  end
  assign match_rise = match & ~match_q;

  always_comb begin
    rd_val = 8'h00;
    if (alm_addr) begin
      rd_val = alarm[idx[ALM_SEL]][idx[2:0]];
    end else begin
      unique case (idx)
        IDX_PROT:  rd_val = {bp, 5'h00};
        IDX_IRQ:   rd_val = intc;
        IDX_ATRIM: rd_val = {2'h0, atrim};
        IDX_DTRIM: rd_val = {5'h00, dtrim};
        IDX_PSW:   rd_val = {bus_off, policy, 3'h0, vts};
        IDX_STAT:  rd_val = {bat_s, flag[1], flag[0], 5'h00};
        default: rd_val = 8'h00;
      endcase
    end
  end

  always_comb begin
    next_alarm = alarm;
    next_bp    = bp;
    next_intc  = intc;
    next_atrim   = atrim;
    next_dtrim   = dtrim;
    next_bus_off = bus_off;
    next_policy  = policy;
    next_vts   = vts;
    next_ack   = req_new;
    next_dat   = req_new ? rd_val : dat;
    if (wr_fire) begin
      if (alm_addr) begin
        next_alarm[idx[ALM_SEL]][idx[2:0]] = wb_dat_i[7:0];
      end
      unique case (idx)
        IDX_PROT:  next_bp    = wb_dat_i[PROT_SEL_LSB +: 3];
        IDX_IRQ:   next_intc  = {wb_dat_i[7:3], 3'h0};
        IDX_ATRIM: next_atrim = wb_dat_i[5:0];
        IDX_DTRIM: next_dtrim = wb_dat_i[2:0];
        IDX_PSW: begin
          next_bus_off = wb_dat_i[PSW_BUS_OFF];
          next_policy  = wb_dat_i[PSW_POLICY];
          next_vts  = wb_dat_i[2:0];
        end
        default: next_bp = bp;
      endcase
    end
    // a match in the clearing cycle survives
    next_flag = (flag & ~{2{sr_rd_fire}}) | match_rise;
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      for (int a = 0; a < 2; a++) begin
        for (int f = 0; f < 8; f++) begin
          alarm[a][f] <= 8'h00;
        end
      end
      bp      <= BP_RST;
      intc    <= IRQ_RST;
      atrim   <= AT_RST;
      dtrim   <= DT_RST;
      bus_off <= 1'b0;
      policy  <= DEF_BSW;
      vts     <= DEF_VTS;
      flag    <= 2'h0;
      ack     <= 1'b0;
      dat     <= 8'h00;
      match_q <= 2'h0;
    end else if (ce_i) begin
      alarm   <= next_alarm;
      bp      <= next_bp;
      intc    <= next_intc;
      atrim   <= next_atrim;
      dtrim   <= next_dtrim;
      bus_off <= next_bus_off;
      policy  <= next_policy;
      vts     <= next_vts;
      flag    <= next_flag;
      ack     <= next_ack;
      dat     <= next_dat;
      match_q <= match;
    end
  end

  // array write gate; the array itself lives outside
  logic prot;
  always_comb begin
    unique case (bp)
      BP_NONE:        prot = 1'b0;
      BP_UPQ:         prot = mem_wr_i.addr >= PA_UPQ;
      BP_UPH:         prot = mem_wr_i.addr >= PA_UPH;
      BP_ALL, BP_ALL2: prot = 1'b1;
      BP_P4:          prot = mem_wr_i.addr <= PA_P4;
      BP_P8:          prot = mem_wr_i.addr <= PA_P8;
      BP_P16:         prot = mem_wr_i.addr <= PA_P16;
    endcase
  end
  assign mem_wr_en_o = mem_wr_i.req & ~prot;

  // second divider with averaged trim correction
  logic [CNT_W-1:0] osc_cnt, next_osc_cnt, term;
  logic [FDIV_W-1:0] div_cnt, next_div_cnt;
  logic [31:0] acc, next_acc, acc_sum;
  logic        adj, next_adj, next_tick;
  logic [5:0]  mag;
  assign mag  = (dtrim[DT_10PPM] ? PPM_STEP_LO : 6'h00) +
                (dtrim[DT_20PPM] ? PPM_STEP_HI : 6'h00);
  // positive correction shortens the second, negative stretches it
  assign term = CNT_W'(OSC_PER_SEC - 1) -
                CNT_W'(adj & ~dtrim[DT_SIGN]) + CNT_W'(adj & dtrim[DT_SIGN]);
  assign acc_sum = acc + 32'(mag) * 32'(OSC_PER_SEC);

  always_comb begin
    next_osc_cnt = osc_cnt;
    next_div_cnt = div_cnt;
    next_acc     = acc;
    next_adj     = adj;
    next_tick    = 1'b0;
    if (osc_rise) begin
      next_div_cnt = div_cnt + 1'b1;
      next_osc_cnt = osc_cnt + 1'b1;
      if (osc_cnt >= term) begin
        next_osc_cnt = '0;
        next_tick    = 1'b1;
        // carry one count whenever a million ppm-counts have built up
        if (acc_sum >= PPM_SCALE) begin
          next_acc = acc_sum - PPM_SCALE;
          next_adj = 1'b1;
        end else begin
          next_acc = acc_sum;
          next_adj = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      osc_cnt    <= '0;
      div_cnt    <= '0;
      acc        <= 32'h00000000;
      adj        <= 1'b0;
      sec_tick_o <= 1'b0;
    end else if (ce_i) begin
      osc_cnt    <= next_osc_cnt;
      div_cnt    <= next_div_cnt;
      acc        <= next_acc;
      adj        <= next_adj;
      sec_tick_o <= next_tick;
    end
  end

  // pulsed alarm sequencer
  rtca_pst_t       pst, next_pst;
  logic [1:0]      pend, next_pend;
  logic [PW-1:0]   pcnt, next_pcnt;
  logic            alarm_low, next_pin;
  always_comb begin
    next_pst  = pst;
    next_pcnt = pcnt;
    next_pend = pend | (match_rise & alen & {2{pulsed}});
    unique case (pst)
      PS_IDLE: begin
        if (pend != 2'h0) begin
          next_pst  = PS_PULSE;
          next_pcnt = '0;
          // one pulse per alarm, alarm 0 first
          next_pend[pend[0] ? 0 : 1] = 1'b0;
          next_pend = next_pend | (match_rise & alen & {2{pulsed}});
        end
      end
      PS_PULSE: begin
        if (osc_rise) begin
          next_pcnt = pcnt + 1'b1;
          if (pcnt == PW'(PULSE_OSC - 1)) begin
            next_pst = PS_IDLE;
          end
        end
      end
    endcase
    if (!pulsed || !match_any_en) begin
      next_pend = 2'h0;
    end
    alarm_low = pulsed ? (pst == PS_PULSE) : ((flag & alen) != 2'h0);
    unique case (fo_sel)
      FO_ALARM: next_pin = ~(alarm_low & match_any_en);
      FO_32K:   next_pin = osc_s;
      FO_4K:    next_pin = div_cnt[FDIV_W-1];
      FO_1HZ:   next_pin = osc_cnt < CNT_W'(OSC_PER_SEC / 2);
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pst            <= PS_IDLE;
      pend           <= 2'h0;
      pcnt           <= '0;
      irq_freq_pin_o <= 1'b1;
    end else if (ce_i) begin
      pst            <= next_pst;
      pend           <= next_pend;
      pcnt           <= next_pcnt;
      irq_freq_pin_o <= next_pin;
    end
  end

  // supply side outputs; the latch ignores the supply recovering above threshold while on battery
  logic next_rst_n;
  always_comb begin
    next_rst_n = rst_n_o;
    if (bat_s && vlow_s) begin
      next_rst_n = 1'b0;
    end else if (!bat_s) begin
      next_rst_n = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rst_n_o                <= 1'b1;
      bus_enable_o           <= 1'b1;
      cap_code_o             <= 7'h00;
      trim_ppm_o             <= 6'h00;
      thresh_sel_o           <= 3'h0;
      supply_switch_policy_o <= 1'b0;
    end else if (ce_i) begin
      rst_n_o                <= next_rst_n;
      bus_enable_o           <= ~(bat_s & bus_off);
      cap_code_o             <= CAP_BASE_HALFPF +
                                {1'b0, ~atrim[AT_MSB], atrim[AT_MSB-1:0]};
      trim_ppm_o             <= dtrim[DT_SIGN] ? 6'(-mag) : mag;
      thresh_sel_o           <= vts;
      supply_switch_policy_o <= policy;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_sr_read;
    ce_i && req_new && !wb_we_i && idx == IDX_STAT;
  endsequence
  sequence s_pulse_start;
    ce_i && pst == PS_IDLE && pend != 2'h0;
  endsequence

  sr_bit3_zero_a: assert property (s_sr_read |=> !wb_dat_o[ST_UNUSED])
    else $error("status bit 3 read as one");
  prot_upper_a: assert property (mem_wr_i.req && bp == BP_UPQ && mem_wr_i.addr >= PA_UPQ
    |-> !mem_wr_en_o)
    else $error("upper quarter write passed");
  prot_lower_a: assert property (mem_wr_i.req && bp == BP_P8 && mem_wr_i.addr <= PA_P8
    |-> !mem_wr_en_o)
    else $error("first pages write passed");
  flag_set_a: assert property (ce_i && match_rise[0] |=> flag[0])
    else $error("alarm flag not set on match");
  flag_clear_a: assert property (ce_i && sr_rd_fire && !match_rise[1] |=> !flag[1])
    else $error("alarm flag not cleared by status read");
  alarm_pin_a: assert property (ce_i && fo_sel == FO_ALARM && !pulsed && (flag & alen) != 2'h0
    |=> !irq_freq_pin_o)
    else $error("single alarm did not drive pin low");
  freq_pin_a: assert property (ce_i && fo_sel == FO_4K
    |=> irq_freq_pin_o == $past(div_cnt[FDIV_W-1]))
    else $error("pin does not follow 4096Hz divider");
  pulse_start_a: assert property (s_pulse_start ##1 (ce_i && fo_sel == FO_ALARM && pulsed
    && match_any_en) |=> !irq_freq_pin_o)
    else $error("pulse did not reach pin");
  pulse_len_a: assert property (pst == PS_PULSE |-> pcnt < PW'(PULSE_OSC))
    else $error("pulse overran its length");
  rst_hold_a: assert property (!rst_n_o && bat_s |=> !rst_n_o)
    else $error("reset released while on battery");
  bus_off_a: assert property (ce_i && bat_s && bus_off |=> !bus_enable_o)
    else $error("bus left on in battery mode");
endmodule

//--- verification/rtca_osc_model.sv
// free running crystal oscillator that feeds the block
`timescale 1ns/10ps
module rtca_osc_model #(
  parameter realtime HALF = 400.0
) (
  output logic osc_o
);
  // a crystal never stops, so no idle level between frames
  initial begin
    osc_o = 1'b0;
    #137;
    forever #(HALF) osc_o = ~osc_o;
  end
endmodule

//--- verification/testbench.sv
// self-checking bench for the alarm, protect and trim control block
`timescale 1ns/10ps
module testbench;
  import rtca_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  rtca_time_t  tm = '0;
  rtca_memwr_t mw = '0;
  logic        osc;
  logic        bat = 1'b0;
  logic        vlow = 1'b0;
  logic        pin, tick, men, pol, busen, rstn;
  logic [6:0]  cap;
  logic [5:0]  ppm;
  logic [2:0]  vts;
  logic [7:0]  expq[$];
  int          num_errors = 0;
  int          num_checks = 0;

  rtca_osc_model u_rtca_osc_model (.osc_o(osc));
  // short second and pulse keep the run brief
  rtca_ctrl #(.OSC_PER_SEC(64), .PULSE_OSC(2)) u_rtca_ctrl (
    .ref_clk_i(clk), .srst_i(srst), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .time_i(tm), .mem_wr_i(mw), .mem_wr_en_o(men), .osc_clk_i(osc),
    .battery_mode_i(bat), .vdd_low_i(vlow), .irq_freq_pin_o(pin), .sec_tick_o(tick),
    .cap_code_o(cap), .trim_ppm_o(ppm), .thresh_sel_o(vts),
    .supply_switch_policy_o(pol), .bus_enable_o(busen), .rst_n_o(rstn));

  always #50 clk = ~clk;

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic hang();
    num_errors++;
    $display("wrong value at %0t: wait ran out", $time);
    end_sim();
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // classic cycle: held until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) hang();
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] i, input logic [7:0] e);
    expq.push_back(e);
    wb(1'b0, i, 8'h00);
  endtask

  task automatic skip(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic watch(input int n, output int fl, output int rs, output int lo,
                       output int tk);
    logic p;
    p = pin;
    fl = 0;
    rs = 0;
    lo = 0;
    tk = 0;
    repeat (n) begin
      @(posedge clk);
      fl += int'(p === 1'b1 && pin === 1'b0);
      rs += int'(p === 1'b0 && pin === 1'b1);
      lo += int'(pin === 1'b0);
      tk += int'(tick === 1'b1);
      p = pin;
    end
  endtask

  function automatic logic prot(input logic [2:0] c, input logic [8:0] a);
    case (c)
      3'h1: return a >= 9'h180;
      3'h2: return a >= 9'h100;
      3'h3, 3'h7: return 1'b1;
      3'h4: return a <= 9'h03F;
      3'h5: return a <= 9'h07F;
      3'h6: return a <= 9'h0FF;
      default: return 1'b0;
    endcase
  endfunction

  // read data is compared against the oldest note
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (expq.size() == 0) hang();
      else chk(rdat[7:0], expq.pop_front());
    end
  end

  initial begin
    logic [8:0] bnd[10] = '{9'h000, 9'h03F, 9'h040, 9'h07F, 9'h080, 9'h0FF, 9'h100,
                            9'h17F, 9'h180, 9'h1FF};
    logic [8:0] a;
    logic [7:0] v;
    int         n, fl, rs, lo, tk, e;
    n = $urandom(32'h6BE6);
    skip(2);
    srst <= 1'b0;
    rd(IDX_IRQ, IRQ_RST);
    rd(IDX_STAT, 8'h00);
    rd(6'h07, 8'h00);
    chk({1'b0, cap}, 8'h32);
    chk({7'h0, busen}, 8'h01);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, IDX_PROT, {c[2:0], 5'h00});
      for (int k = 0; k < 12; k++) begin
        a = (k < 10) ? bnd[k] : 9'($urandom);
        mw <= {1'b1, a};
        @(posedge clk);
        chk({7'h0, men}, {7'h0, !prot(c[2:0], a)});
      end
    end
    $display("test protect done");
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, IDX_DTRIM, 8'(c));
      v = 8'($urandom) & 8'h3F;
      wb(1'b1, IDX_ATRIM, v);
      skip(2);
      n = (c[1] ? 10 : 0) + (c[0] ? 20 : 0);
      chk({2'b0, ppm}, {2'b0, 6'(c[2] ? -n : n)});
      chk({1'b0, cap}, 8'h12 + (v[5] ? 8'h00 : 8'h20) + {3'h0, v[4:0]});
      rd(IDX_DTRIM, 8'(c));
    end
    $display("test trim done");
    // whole array still protected: threshold must stay writable
    for (int c = 0; c < 5; c++) begin
      v = {1'b0, c[0], 3'h0, c[2:0]};
      wb(1'b1, IDX_PSW, v);
      skip(2);
      chk({5'h0, vts}, {5'h0, v[2:0]});
      chk({7'h0, pol}, {7'h0, v[6]});
    end
    wb(1'b1, IDX_PSW, 8'h80);
    bat <= 1'b1;
    skip(5);
    chk({7'h0, busen}, 8'h00);
    vlow <= 1'b1; // supply kept above threshold until now
    skip(5);
    chk({7'h0, rstn}, 8'h00);
    vlow <= 1'b0;
    skip(5);
    chk({7'h0, rstn}, 8'h00);
    bat <= 1'b0;
    skip(5);
    chk({7'h0, rstn}, 8'h01);
    chk({7'h0, busen}, 8'h01);
    $display("test supply done");
    for (int i = 1; i < 15; i++)
      if (i != 7) wb(1'b1, 6'(i), (i == 5) ? 8'hB3 : (i == 9) ? 8'hB0 : (i == 10) ? 8'h87 : 8'h00);
    wb(1'b1, 6'h00, 8'h95);
    wb(1'b1, IDX_IRQ, 8'h00);
    tm.sc <= 8'h15;
    tm.yr <= 8'h20;
    watch(10, fl, rs, lo, tk);
    chk(8'(lo), 8'h00);
    rd(IDX_STAT, 8'h20);
    wb(1'b1, IDX_IRQ, 8'h20);
    tm.sc <= 8'h00;
    skip(2);
    tm.sc <= 8'h15;
    skip(4);
    chk({7'h0, pin}, 8'h00);
    rd(IDX_STAT, 8'h20);
    skip(2);
    chk({7'h0, pin}, 8'h01);
    wb(1'b1, IDX_IRQ, 8'h60);
    tm.mn <= 8'h30;
    tm.hr <= 8'h06;
    skip(4);
    rd(IDX_STAT, 8'h00);
    tm.hr <= 8'h07;
    skip(4);
    chk({7'h0, pin}, 8'h00);
    rd(IDX_STAT, 8'h40);
    $display("test single alarm done");
    tm.sc <= 8'h00;
    tm.hr <= 8'h06;
    wb(1'b1, IDX_IRQ, 8'hE0);
    for (int r = 0; r < 2; r++) begin
      tm.sc <= 8'h15;
      tm.hr <= 8'h07;
      watch(200, fl, rs, lo, tk);
      chk(8'(fl), 8'h02);
      chk({7'h0, lo >= 16 && lo <= 40}, 8'h01);
      chk({7'h0, pin}, 8'h01);
      tm.sc <= 8'h00;
      tm.hr <= 8'h06;
      skip(4);
    end
    $display("test pulsed alarm done");
    for (int f = 1; f < 4; f++) begin
      wb(1'b1, IDX_IRQ, {3'b001, f[1:0], 3'h0});
      watch(1024, fl, rs, lo, tk);
      e = (f == 1) ? 128 : (f == 2) ? 16 : 2;
      chk({7'h0, rs >= e - 1 && rs <= e + 1}, 8'h01);
      chk({7'h0, tk >= 1 && tk <= 3}, 8'h01);
    end
    $display("test frequency done");
    end_sim();
  end
endmodule
